/* nvsc_pkg.sv */
package nvsc_pkg;

  localparam int NVSC_ADDR_W = 19;
  localparam int NVSC_DATA_W = 16;
  localparam int NVSC_CLK_NS = 10;

  // Access timing toward the memory, in ns
  localparam int NVSC_ACCESS_NS = 25;
  localparam int NVSC_SETUP_NS = 15;
  localparam int NVSC_RECOVER_NS = 10;
  localparam int NVSC_ACCESS_CYC = (NVSC_ACCESS_NS + NVSC_CLK_NS - 1) / NVSC_CLK_NS;
  localparam int NVSC_SETUP_CYC = (NVSC_SETUP_NS + NVSC_CLK_NS - 1) / NVSC_CLK_NS;
  localparam int NVSC_RECOVER_CYC = (NVSC_RECOVER_NS + NVSC_CLK_NS - 1) / NVSC_CLK_NS;
  localparam int NVSC_HSB_PULSE_NS = 100;
  localparam int NVSC_HSB_PULSE_CYC = (NVSC_HSB_PULSE_NS + NVSC_CLK_NS - 1) / NVSC_CLK_NS;

  // Software sequence addresses
  localparam logic [15:0] NVSC_SEQ_A1 = 16'h4e38;
  localparam logic [15:0] NVSC_SEQ_A2 = 16'hb1c7;
  localparam logic [15:0] NVSC_SEQ_A3 = 16'h83e0;
  localparam logic [15:0] NVSC_SEQ_A4 = 16'h7c1f;
  localparam logic [15:0] NVSC_SEQ_A5 = 16'h703f;
  localparam logic [15:0] NVSC_SEQ_SAVE = 16'h8fc0;
  localparam logic [15:0] NVSC_SEQ_RESTORE = 16'h4c63;
  localparam logic [15:0] NVSC_SEQ_NOAUTO = 16'h8b45;

  typedef enum logic [1:0] {
    NVSC_CMD_READ = 2'b00,
    NVSC_CMD_WRITE = 2'b01,
    NVSC_CMD_SAVE = 2'b10,
    NVSC_CMD_RESTORE = 2'b11
  } nvsc_cmd_t;

endpackage

/* nvsc_cnt.sv */
`timescale 1ns/10ps
`default_nettype none
module nvsc_cnt #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  output logic done
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = loadVal;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Done must not look at load: the user derives load from done
  assign done = (cnt_ff == '0);

endmodule
`default_nettype wire

/* nvsc_host.sv */
`timescale 1ns/10ps
`default_nettype none
module nvsc_host
  import nvsc_pkg::*;
#(
  parameter int ACCESS_CYC = NVSC_ACCESS_CYC,
  parameter int SETUP_CYC = NVSC_SETUP_CYC,
  parameter int RECOVER_CYC = NVSC_RECOVER_CYC,
  parameter int HSB_PULSE_CYC = NVSC_HSB_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // User request
  input wire logic reqValid,
  output logic reqReady,
  input wire nvsc_cmd_t reqCmd,
  input wire logic [NVSC_ADDR_W-1:0] reqAddr,
  input wire logic [NVSC_DATA_W-1:0] reqWdata,
  input wire logic [1:0] reqLanes,
  input wire logic wordMode,
  // User answer
  output logic rspValid,
  output logic [NVSC_DATA_W-1:0] rspRdata,
  output logic memBusy,
  // Memory pins
  output logic chipSel_n,
  output logic outEn_n,
  output logic writeEn_n,
  output logic upper_byte_enable_n,
  output logic lower_byte_enable_n,
  output logic [NVSC_ADDR_W-1:0] memAddr,
  input wire logic [NVSC_DATA_W-1:0] dqIn,
  output logic [NVSC_DATA_W-1:0] dqOut,
  output logic dqOe,
  input wire logic store_busy_n_in,
  output logic store_busy_n_out,
  output logic store_busy_n_oe
);

  // ****************************************
  // State machine
  // ****************************************
  typedef enum logic [2:0] {
    NVSC_IDLE = 3'b000,
    NVSC_SETUP = 3'b001,
    NVSC_STROBE = 3'b010,
    NVSC_RECOVER = 3'b011,
    NVSC_SEQ = 3'b100,
    NVSC_HSBREQ = 3'b101,
    NVSC_WAITBUSY = 3'b110
  } nvsc_state_t;

  nvsc_state_t state_ff, nxt_state;
  nvsc_cmd_t cmd_ff, nxt_cmd;
  logic [NVSC_ADDR_W-1:0] addr_ff, nxt_addr;
  logic [NVSC_DATA_W-1:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [1:0] lanes_ff, nxt_lanes;
  logic [2:0] seqIdx_ff, nxt_seqIdx;
  logic rsp_ff, nxt_rsp;
  logic cntLoad;
  logic [7:0] cntVal;
  logic cntDone;
  logic [15:0] seqAddr;

  nvsc_cnt #(.W(8)) uTimer (
    .clk(clk),
    .rst_b(rst_b),
    .load(cntLoad),
    .loadVal(cntVal),
    .done(cntDone)
  );

  // Sequence table; last entry picks save, restore or the no-autosave address (restore with address bit 0 set)
  always_comb begin
    case (seqIdx_ff)
      3'd0: seqAddr = NVSC_SEQ_A1;
      3'd1: seqAddr = NVSC_SEQ_A2;
      3'd2: seqAddr = NVSC_SEQ_A3;
      3'd3: seqAddr = NVSC_SEQ_A4;
      3'd4: seqAddr = NVSC_SEQ_A5;
      default: begin
        if (cmd_ff == NVSC_CMD_SAVE) begin
          seqAddr = NVSC_SEQ_SAVE;
        end else if (addr_ff[0]) begin
          seqAddr = NVSC_SEQ_NOAUTO;
        end else begin
          seqAddr = NVSC_SEQ_RESTORE;
        end
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_lanes = lanes_ff;
    nxt_seqIdx = seqIdx_ff;
    nxt_rsp = 1'b0;
    cntLoad = 1'b0;
    cntVal = 8'h00;
    case (state_ff)
      NVSC_IDLE: begin
        // Busy pin low blocks every access
        if (reqValid && store_busy_n_in) begin
          nxt_cmd = reqCmd;
          nxt_addr = reqAddr;
          nxt_wdata = reqWdata;
          nxt_lanes = wordMode ? reqLanes : 2'b11;
          nxt_seqIdx = 3'd0;
          cntLoad = 1'b1;
          if (reqCmd == NVSC_CMD_READ || reqCmd == NVSC_CMD_WRITE) begin
            cntVal = 8'(SETUP_CYC);
            nxt_state = NVSC_SETUP;
          end else if (reqCmd == NVSC_CMD_SAVE && !wordMode && reqAddr[0]) begin
            // Address bit 0 set on a save in byte mode (wordMode low) asks for the pin save path
            cntVal = 8'(HSB_PULSE_CYC);
            nxt_state = NVSC_HSBREQ;
          end else begin
            // Bit 0 on a restore turns off the power-down save instead
            nxt_addr = {{(NVSC_ADDR_W-1){1'b0}}, (reqCmd == NVSC_CMD_RESTORE) && reqAddr[0]};
            cntVal = 8'(SETUP_CYC);
            nxt_state = NVSC_SEQ;
          end
        end
      end
      NVSC_SETUP: begin
        // Address stable before strobe
        if (cntDone) begin
          cntLoad = 1'b1;
          cntVal = 8'(ACCESS_CYC);
          nxt_state = NVSC_STROBE;
        end
      end
      NVSC_STROBE: begin
        if (cntDone) begin
          if (cmd_ff == NVSC_CMD_READ) begin
            nxt_rdata = dqIn;
          end
          nxt_rsp = 1'b1;
          cntLoad = 1'b1;
          cntVal = 8'(RECOVER_CYC);
          nxt_state = NVSC_RECOVER;
        end
      end
      NVSC_RECOVER: begin
        if (cntDone) begin
          nxt_state = NVSC_IDLE;
        end
      end
      NVSC_SEQ: begin
        // Six back-to-back reads, nothing in between
        if (cntDone) begin
          cntLoad = 1'b1;
          if (seqIdx_ff == 3'd5) begin
            cntVal = 8'(RECOVER_CYC);
            nxt_state = NVSC_WAITBUSY;
          end else begin
            cntVal = 8'(ACCESS_CYC);
            nxt_seqIdx = seqIdx_ff + 3'd1;
          end
        end
      end
      NVSC_HSBREQ: begin
        if (cntDone) begin
          cntLoad = 1'b1;
          cntVal = 8'(RECOVER_CYC);
          nxt_state = NVSC_WAITBUSY;
        end
      end
      NVSC_WAITBUSY: begin
        // Done once device has released the busy pin
        if (cntDone && store_busy_n_in) begin
          nxt_rsp = 1'b1;
          nxt_state = NVSC_IDLE;
        end
      end
      default: nxt_state = NVSC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= NVSC_IDLE;
      cmd_ff <= NVSC_CMD_READ;
      addr_ff <= '0;
      wdata_ff <= '0;
      rdata_ff <= '0;
      lanes_ff <= 2'b00;
      seqIdx_ff <= 3'd0;
      rsp_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      lanes_ff <= nxt_lanes;
      seqIdx_ff <= nxt_seqIdx;
      rsp_ff <= nxt_rsp;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  logic isWrite, inAccess, inSeq;
  assign isWrite = (cmd_ff == NVSC_CMD_WRITE);
  assign inAccess = (state_ff == NVSC_STROBE);
  assign inSeq = (state_ff == NVSC_SEQ) && (seqIdx_ff != 3'd0 || cntDone);

  // Write enable held high out of reset and for all sequence reads
  assign chipSel_n = !(inAccess || inSeq);
  assign writeEn_n = !(inAccess && isWrite);
  assign outEn_n = !((inAccess && !isWrite) || inSeq);
  assign upper_byte_enable_n = !lanes_ff[1];
  assign lower_byte_enable_n = !lanes_ff[0];
  assign memAddr = (state_ff == NVSC_SEQ) ? {3'b000, seqAddr} : addr_ff;
  // Data driven from setup through strobe end
  assign dqOut = wdata_ff;
  assign dqOe = isWrite && (state_ff == NVSC_SETUP || state_ff == NVSC_STROBE);
  assign store_busy_n_out = 1'b0;
  assign store_busy_n_oe = (state_ff == NVSC_HSBREQ);
  assign reqReady = (state_ff == NVSC_IDLE) && store_busy_n_in;
  assign rspValid = rsp_ff;
  assign rspRdata = rdata_ff;
  assign memBusy = !store_busy_n_in;

  // ****************************************
  // Checks
  // ****************************************
  sequence seqReadEnd;
    (state_ff == NVSC_SEQ) && (seqIdx_ff == 3'd5) && cntDone;
  endsequence

  oe_off_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    !writeEn_n |-> outEn_n) else $error("output enable low during write");
  we_in_seq_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == NVSC_SEQ) |-> writeEn_n) else $error("write enable low in sequence");
  seq_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
    seqReadEnd |=> (state_ff == NVSC_WAITBUSY)) else $error("sequence did not finish");
  addr_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !writeEn_n && $past(!writeEn_n) |-> $stable(memAddr)) else $error("address moved in write");
  data_setup_a: assert property (@(posedge clk) disable iff (!rst_b)
    !writeEn_n |-> dqOe) else $error("write data not driven");
  busy_pull_a: assert property (@(posedge clk) disable iff (!rst_b)
    store_busy_n_oe |-> !store_busy_n_out && chipSel_n) else $error("busy pin driven high or access open");
  no_access_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == NVSC_IDLE) && !store_busy_n_in |=> (state_ff == NVSC_IDLE)) else $error("started while busy");
  rsp_after_strobe_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state_ff == NVSC_STROBE) && cntDone |=> rspValid) else $error("no answer after access");

endmodule
`default_nettype wire

/* nvsc_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module nvsc_mem_model
  import nvsc_pkg::*;
#(
  parameter int SAVE_CYC = 40,
  parameter int DELAY_CYC = 3
) (
  // Clock and configuration
  input wire logic clk,
  input wire logic wordMode,
  // Memory pins
  input wire logic chipSel_n,
  input wire logic outEn_n,
  input wire logic writeEn_n,
  input wire logic upper_byte_enable_n,
  input wire logic lower_byte_enable_n,
  input wire logic [NVSC_ADDR_W-1:0] addr,
  input wire logic [NVSC_DATA_W-1:0] dqBus,
  output logic [NVSC_DATA_W-1:0] dqDev = 16'h0000,
  input wire logic busyPin,
  input wire logic powerFail,
  output logic busyLow = 1'b0,
  output logic busyHigh = 1'b0,
  // Event counts
  output int saveCnt = 0,
  output int restoreCnt = 0
);
  // ****************
  // Device behaviour
  // ****************
  logic [7:0] mem [int];
  logic [7:0] nv [int];
  logic [15:0] seqA [5] = '{NVSC_SEQ_A1, NVSC_SEQ_A2, NVSC_SEQ_A3, NVSC_SEQ_A4, NVSC_SEQ_A5};
  logic pend = 1'b0;
  logic rdPrev = 1'b0;
  logic isSave = 1'b0;
  logic autoEn = 1'b1;
  logic [NVSC_ADDR_W-1:0] lastA = '0;
  int busyCnt = 0;
  int dly = 0;
  int step = 0;
  int bi;
  wire rd = !chipSel_n && !outEn_n && writeEn_n && busyPin;
  wire wr = !chipSel_n && !writeEn_n && busyPin;

  function automatic logic [7:0] rb(input int i);
    return mem.exists(i) ? mem[i] : 8'h00;
  endfunction

  // Idle lanes toggle so a stale value never reads as valid
  always @(posedge clk) begin
    bi = wordMode ? int'({addr[17:0], 1'b0}) : int'(addr);
    dqDev <= ~dqDev;
    busyHigh <= 1'b0;
    if (busyCnt > 0) begin
      busyCnt <= busyCnt - 1;
      if (busyCnt == 1) begin
        busyLow <= 1'b0;
        pend <= 1'b0;
        if (isSave) begin
          nv = mem;
          saveCnt <= saveCnt + 1;
          busyHigh <= 1'b1;
        end else begin
          mem.delete();
          mem = nv;
          restoreCnt <= restoreCnt + 1;
        end
      end
    end else if (powerFail && autoEn && pend) begin
      busyCnt <= SAVE_CYC;
      busyLow <= 1'b1;
      isSave <= 1'b1;
    end else if (!busyPin && pend) begin
      dly <= dly + 1;
      if (dly == DELAY_CYC) begin
        busyCnt <= SAVE_CYC;
        busyLow <= 1'b1;
        isSave <= 1'b1;
      end
    end else begin
      dly <= 0;
      if (wr) begin
        pend <= 1'b1;
        step <= 0;
        if (!wordMode || !lower_byte_enable_n) mem[bi] = dqBus[7:0];
        if (wordMode && !upper_byte_enable_n) mem[bi + 1] = dqBus[15:8];
      end
      if (rd) begin
        if (!wordMode || !lower_byte_enable_n) dqDev[7:0] <= rb(bi);
        if (wordMode && !upper_byte_enable_n) dqDev[15:8] <= rb(bi + 1);
      end
      if (rd && (!rdPrev || addr != lastA)) begin
        if (step == 5 && addr[15:0] == NVSC_SEQ_NOAUTO) begin
          autoEn <= 1'b0;
          step <= 0;
        end else if (step == 5 && addr[15:0] inside {NVSC_SEQ_SAVE, NVSC_SEQ_RESTORE}) begin
          busyCnt <= SAVE_CYC;
          busyLow <= 1'b1;
          isSave <= addr[15:0] == NVSC_SEQ_SAVE;
          step <= 0;
        end else if (step < 5 && addr[15:0] == seqA[step]) step <= step + 1;
        else step <= (addr[15:0] == seqA[0]) ? 1 : 0;
      end
    end
    rdPrev <= rd;
    lastA <= addr;
  end
endmodule
`default_nettype wire

/* nv_sram_access_and_store_control_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module nv_sram_access_and_store_control_bench
  import nvsc_pkg::*;
;
  // *******
  // Signals
  // *******
  logic clk, rst_b, reqValid, reqReady, wordMode, rspValid, memBusy;
  nvsc_cmd_t reqCmd;
  logic [18:0] reqAddr, memAddr;
  logic [15:0] reqWdata, rspRdata, dqIn, dqOut, devDq;
  logic [1:0] reqLanes;
  logic ceN, oeN, weN, ubeN, lbeN, dqOe, busyPin, busyOut, busyOe, busyLow, busyHigh, powerFail;
  int saveCnt, restoreCnt, miscompares, checks, cycles;
  assign dqIn = dqOe ? dqOut : devDq;
  assign busyPin = busyOe ? busyOut : (!busyLow || busyHigh);

  nvsc_host nvsc_host_inst (.clk(clk), .rst_b(rst_b), .reqValid(reqValid), .reqReady(reqReady),
    .reqCmd(reqCmd), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqLanes(reqLanes), .wordMode(wordMode),
    .rspValid(rspValid), .rspRdata(rspRdata), .memBusy(memBusy), .chipSel_n(ceN), .outEn_n(oeN),
    .writeEn_n(weN), .upper_byte_enable_n(ubeN), .lower_byte_enable_n(lbeN), .memAddr(memAddr),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .store_busy_n_in(busyPin), .store_busy_n_out(busyOut),
    .store_busy_n_oe(busyOe));
  nvsc_mem_model nvsc_mem_model_inst (.clk(clk), .wordMode(wordMode), .chipSel_n(ceN), .outEn_n(oeN),
    .writeEn_n(weN), .upper_byte_enable_n(ubeN), .lower_byte_enable_n(lbeN), .addr(memAddr),
    .dqBus(dqIn), .dqDev(devDq), .busyPin(busyPin), .powerFail(powerFail), .busyLow(busyLow), .busyHigh(busyHigh),
    .saveCnt(saveCnt), .restoreCnt(restoreCnt));

  always #5 clk = ~clk;

  // *********
  // Scenarios
  // *********
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Busy pin must hold requests back while it is low
  task automatic req(input nvsc_cmd_t c, input logic [18:0] a, input logic [15:0] d, input logic [1:0] l,
                     input logic w);
    int n;
    n = 0;
    {reqCmd, reqAddr, reqWdata, reqLanes, wordMode, reqValid} = {c, a, d, l, w, 1'b1};
    // Ready is judged settled, then the request stands through the taking edge
    while (reqReady !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    #1 reqValid = 1'b0;
    while (rspValid !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1 n++;
      if (memBusy === 1'b1) chk(16'(reqReady), 16'h0000);
    end
    chk(16'(n < 1000), 16'h0001);
  endtask

  task automatic s_byte();
    req(NVSC_CMD_WRITE, 19'h7ffff, 16'h00a5, 2'b11, 1'b0);
    req(NVSC_CMD_WRITE, 19'h00000, 16'h003c, 2'b11, 1'b0);
    req(NVSC_CMD_READ, 19'h7ffff, 16'h0000, 2'b11, 1'b0);
    chk(16'(rspRdata[7:0]), 16'h00a5);
    req(NVSC_CMD_READ, 19'h00000, 16'h0000, 2'b11, 1'b0);
    chk(16'(rspRdata[7:0]), 16'h003c);
  endtask

  task automatic s_word();
    req(NVSC_CMD_WRITE, 19'h3ffff, 16'h1234, 2'b11, 1'b1);
    req(NVSC_CMD_WRITE, 19'h3ffff, 16'habcd, 2'b01, 1'b1);
    req(NVSC_CMD_WRITE, 19'h3ffff, 16'h5600, 2'b10, 1'b1);
    req(NVSC_CMD_READ, 19'h3ffff, 16'h0000, 2'b11, 1'b1);
    chk(rspRdata, 16'h56cd);
    req(NVSC_CMD_READ, 19'h3ffff, 16'h0000, 2'b01, 1'b1);
    chk(16'(rspRdata[7:0]), 16'h00cd);
  endtask

  // Writes are pending here, so the first pin save must run
  task automatic s_save();
    int s;
    s = saveCnt;
    req(NVSC_CMD_SAVE, 19'h00001, 16'h0000, 2'b11, 1'b0);
    chk(16'(saveCnt - s), 16'h0001);
    req(NVSC_CMD_SAVE, 19'h00001, 16'h0000, 2'b11, 1'b0);
    chk(16'(saveCnt - s), 16'h0001);
    req(NVSC_CMD_SAVE, 19'h00000, 16'h0000, 2'b11, 1'b0);
    chk(16'(saveCnt - s), 16'h0002);
  endtask

  task automatic s_restore();
    req(NVSC_CMD_WRITE, 19'h00005, 16'h0011, 2'b11, 1'b0);
    req(NVSC_CMD_SAVE, 19'h00000, 16'h0000, 2'b11, 1'b0);
    req(NVSC_CMD_WRITE, 19'h00005, 16'h0022, 2'b11, 1'b0);
    req(NVSC_CMD_RESTORE, 19'h00000, 16'h0000, 2'b11, 1'b0);
    chk(16'(restoreCnt), 16'h0001);
    req(NVSC_CMD_READ, 19'h00005, 16'h0000, 2'b11, 1'b0);
    chk(16'(rspRdata[7:0]), 16'h0011);
  endtask

  task automatic fail_pulse(input logic exp);
    powerFail = 1'b1;
    @(posedge clk);
    #1 powerFail = 1'b0;
    chk(16'(memBusy), 16'(exp));
    repeat (60) @(posedge clk);
    #1;
  endtask

  // Power loss saves only with a write pending and the feature on
  task automatic s_auto();
    int s;
    s = saveCnt;
    req(NVSC_CMD_WRITE, 19'h00009, 16'h0077, 2'b11, 1'b0);
    fail_pulse(1'b1);
    chk(16'(saveCnt - s), 16'h0001);
    fail_pulse(1'b0);
    chk(16'(saveCnt - s), 16'h0001);
    req(NVSC_CMD_WRITE, 19'h00009, 16'h0066, 2'b11, 1'b0);
    req(NVSC_CMD_RESTORE, 19'h00001, 16'h0000, 2'b11, 1'b0);
    fail_pulse(1'b0);
    chk(16'(saveCnt - s), 16'h0001);
    chk(16'(restoreCnt), 16'h0001);
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    reqValid = 1'b0;
    reqCmd = NVSC_CMD_READ;
    reqAddr = '0;
    reqWdata = '0;
    reqLanes = 2'b11;
    wordMode = 1'b0;
    powerFail = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    s_byte();
    s_word();
    s_save();
    s_restore();
    s_auto();
    end_of_test();
  end
endmodule
`default_nettype wire
